// *** hdl/drfpt_core.sv ***
// DDR2 command scheduler core: refresh scheduling, automatic power saving, command spacing.
// Assumes an APB master, a requester that holds its request until done, one 40 MHz clock.
// Functional notes
// - Chip select is the shifted user address ANDed with the chip-select mask.
// - Bank is the shifted user address ANDed with the bank mask.
// - Pending refreshes never exceed the programmed maximum.
// - When idle, pending refreshes issue one after another, each held to the refresh spacing, until a request.
// - At the pending maximum, requests wait until the pending refreshes drain.
// - Refresh commands are spaced by at least the refresh spacing field.
// - Refreshes fall due on average once per programmed interval count.
// - Precharge-only bit forces precharging open rows before power-down.
// - Self-refresh entry waits for idle time of delay times 1024 clocks.
// - Power-down entry waits for idle time of delay times four clocks.
// - Automatic self-refresh happens only when its enable bit is one.
// - Automatic power-down happens only when its enable bit is one.
// - Read-modify-write keeps its read and write apart by the gap.
// - Read then write keeps the read-to-write gap for any chip select.
// - Write then write keeps same or cross chip-select gap.
// - Read then read keeps same or cross chip-select gap.
// - Write then read keeps same or cross chip-select gap.
// - Unused bits read zero except bits 29 and 26 of command_spacing_config1; configuration resets to zero.
// - Power-down keeps its minimum stay and its exit delay.
// - Self-refresh keeps its minimum stay and its nine-bit exit delay.
`timescale 1ns/10ps
`include "drfpt_map.svh"
module drfpt_core
#(
   parameter int ADDR_W = 8,
   parameter int GAP_W = 5,
   parameter int IDLE_W = 20
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_rmw,
   input wire logic [31:0] req_addr,
   output logic req_done,
   output logic cmd_valid,
   output drfpt_pkg::drfpt_cmd_t cmd_code,
   output logic [2:0] cmd_cs,
   output logic [2:0] cmd_bank,
   output logic mem_cke
);
   import drfpt_pkg::*;

   // ************************************************************
   // Register file
   // ************************************************************
   localparam int NCFG = 6;
   localparam int UNMAPPED = 7;
   localparam logic [31:0] WMASK [0:NCFG-1] = '{
      `DRFPT_MSK_CSBANK, `DRFPT_MSK_REFRESH, `DRFPT_MSK_POWER,
      `DRFPT_MSK_SPACE0, `DRFPT_MSK_SPACE1, `DRFPT_MSK_SHIFT
   };
   localparam logic [2:0] IDX_STATUS = 3'(`DRFPT_OFS_STATUS >> 2);

   // Offsets are four times the index, so the decode is a plain slice.
   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [2:0] idx;
      idx = a[4:2];
      if (a[1:0] != 2'b00 || (a >> 5) != '0 || idx > IDX_STATUS)
      begin
         idx = 3'(UNMAPPED);
      end
      return idx;
   endfunction

   function automatic logic [GAP_W-1:0] bump(input logic [GAP_W-1:0] v);
      return (v == '1) ? v : v + 1'b1;
   endfunction

   logic [31:0] cfg [0:NCFG-1];
   wire apb_setup = psel & ~penable;
   wire bus_write = psel & penable & pready & pwrite;
   wire [2:0] sel_idx = reg_index(paddr);

   generate
      for (genvar i = 0; i < NCFG; i++)
      begin : g_cfg
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               cfg[i] <= `DRFPT_RST_WORD;
            else if (bus_write && sel_idx == 3'(i))
               cfg[i] <= pwdata & WMASK[i];
         end
      end
   endgenerate

   wire [31:0] chip_select_bank_mask_config = cfg[0];
   wire [31:0] refresh_config = cfg[1];
   wire [31:0] power_save_config = cfg[2];
   wire [31:0] command_spacing_config0 = cfg[3];
   wire [31:0] command_spacing_config1 = cfg[4];
   wire [31:0] address_shift_config = cfg[5];

   // ************************************************************
   // Field extraction
   // ************************************************************
   wire [2:0] chip_select_mask = chip_select_bank_mask_config[`DRFPT_F_CSMSK];
   wire [2:0] bank_mask = chip_select_bank_mask_config[`DRFPT_F_BNKMSK];
   wire [4:0] chip_select_shift = address_shift_config[`DRFPT_F_CSSH];
   wire [4:0] bank_shift = address_shift_config[`DRFPT_F_BNKSH];
   wire [2:0] max_pending_refresh = refresh_config[`DRFPT_F_MAXREF];
   wire [7:0] refresh_min_spacing = refresh_config[`DRFPT_F_REFSP];
   wire [15:0] refresh_interval_count = refresh_config[`DRFPT_F_REFINT];
   wire precharge_only_powerdown = power_save_config[`DRFPT_B_PCHONLY];
   wire [9:0] selfrefresh_idle_delay = power_save_config[`DRFPT_F_SRDLY];
   wire [7:0] powerdown_idle_delay = power_save_config[`DRFPT_F_PDDLY];
   wire auto_selfrefresh_enable = power_save_config[`DRFPT_B_ASREN];
   wire auto_powerdown_enable = power_save_config[`DRFPT_B_APDEN];
   wire [GAP_W-1:0] rmw_read_write_gap = GAP_W'(command_spacing_config0[`DRFPT_F_RMW]);
   wire [GAP_W-1:0] read_write_gap = GAP_W'(command_spacing_config0[`DRFPT_F_R2W]);
   wire [GAP_W-1:0] write_write_cross_cs_gap = GAP_W'(command_spacing_config0[`DRFPT_F_W2WCS]);
   wire [GAP_W-1:0] write_write_gap = GAP_W'(command_spacing_config0[`DRFPT_F_W2W]);
   wire [GAP_W-1:0] read_read_cross_cs_gap = GAP_W'(command_spacing_config0[`DRFPT_F_R2RCS]);
   wire [GAP_W-1:0] read_read_gap = GAP_W'(command_spacing_config0[`DRFPT_F_R2R]);
   wire [GAP_W-1:0] write_read_cross_cs_gap = GAP_W'({
      command_spacing_config1[`DRFPT_B_W2RCSHI], command_spacing_config0[`DRFPT_F_W2RCS]});
   wire [GAP_W-1:0] write_read_gap = GAP_W'({
      command_spacing_config1[`DRFPT_B_W2RHI], command_spacing_config0[`DRFPT_F_W2R]});
   wire [8:0] powerdown_exit_gap = 9'(command_spacing_config1[`DRFPT_F_PDEXIT]);
   wire [8:0] powerdown_min_stay = 9'(command_spacing_config1[`DRFPT_F_PDMIN]);
   wire [8:0] selfrefresh_exit_gap = {
      command_spacing_config1[`DRFPT_B_SREXHI], command_spacing_config1[`DRFPT_F_SREXIT]};
   wire [8:0] selfrefresh_min_stay = 9'(command_spacing_config1[`DRFPT_F_SRMIN]);

   // ************************************************************
   // Scheduler state
   // ************************************************************
   drfpt_pstate_t pstate, next_state;
   drfpt_cmd_t next_cmd;
   logic [GAP_W-1:0] since_rd, since_wr;
   logic [7:0] since_ref;
   logic [2:0] last_rd_cs, last_wr_cs;
   logic [15:0] ref_cnt;
   logic [2:0] pending;
   logic ref_block;
   logic rows_open;
   logic rmw_wr;
   logic [IDLE_W-1:0] idle_cnt;
   logic [8:0] st_cnt;

   wire [31:0] cs_shifted = req_addr >> chip_select_shift;
   wire [2:0] req_cs = cs_shifted[2:0] & chip_select_mask;
   wire [31:0] bank_shifted = req_addr >> bank_shift;
   wire [2:0] req_bank = bank_shifted[2:0] & bank_mask;

   // ************************************************************
   // Command spacing
   // ************************************************************
   wire is_wr = rmw_wr | (req_write & ~req_rmw);
   wire same_wr_cs = (req_cs == last_wr_cs);
   wire same_rd_cs = (req_cs == last_rd_cs);
   wire ok_w2r = since_wr >= (same_wr_cs ? write_read_gap : write_read_cross_cs_gap);
   wire ok_r2r = since_rd >= (same_rd_cs ? read_read_gap : read_read_cross_cs_gap);
   wire ok_r2w = since_rd >= read_write_gap;
   wire ok_rmw = ~rmw_wr | (since_rd >= rmw_read_write_gap);
   wire ok_w2w = since_wr >= (same_wr_cs ? write_write_gap : write_write_cross_cs_gap);
   wire user_ok = is_wr ? (ok_r2w & ok_rmw & ok_w2w) : (ok_w2r & ok_r2r);

   // ************************************************************
   // Refresh scheduling
   // ************************************************************
   // The interval counter stops in self-refresh, where the memory refreshes itself.
   wire ref_run = (pstate != PS_SR) && (refresh_interval_count != 16'h0000);
   wire ref_tick = ref_run && (ref_cnt >= refresh_interval_count - 16'h0001);
   wire [15:0] next_ref_cnt = ref_tick ? 16'h0000 : (ref_run ? ref_cnt + 16'h0001 : ref_cnt);
   wire pend_inc = ref_tick && (pending < max_pending_refresh);
   wire pend_dec = (next_cmd == CMD_REFRESH);
   wire [2:0] pend_sum = pending + {2'b00, pend_inc} - {2'b00, pend_dec};
   wire [2:0] next_pending = (pend_sum > max_pending_refresh) ? max_pending_refresh : pend_sum;
   // hold requests at the maximum until drained
   wire at_max = (next_pending == max_pending_refresh) && (max_pending_refresh != 3'b000);
   wire next_ref_block = at_max | (ref_block & (next_pending != 3'b000));
   wire ref_spaced = since_ref >= refresh_min_spacing;
   wire can_ref = (pending != 3'b000) && ref_spaced && (~req_valid | ref_block);

   // ************************************************************
   // Idle tracking and power saving decisions
   // ************************************************************
   wire idle_now = ~req_valid && (pending == 3'b000) && ~rmw_wr;
   wire [IDLE_W-1:0] next_idle = idle_now ? ((idle_cnt == '1) ? idle_cnt : idle_cnt + 1'b1) : '0;
   wire [IDLE_W-1:0] pd_thr = IDLE_W'(powerdown_idle_delay) << `DRFPT_PD_UNIT_LOG2;
   wire [IDLE_W-1:0] sr_thr = IDLE_W'(selfrefresh_idle_delay) << `DRFPT_SR_UNIT_LOG2;
   wire sr_go = auto_selfrefresh_enable && (selfrefresh_idle_delay != 10'h000)
      && (idle_cnt >= sr_thr);
   wire pd_go = auto_powerdown_enable && (powerdown_idle_delay != 8'h00)
      && (idle_cnt >= pd_thr);
   // precharge-only power-down; self-refresh always closes rows first
   wire need_pre = rows_open && (sr_go || precharge_only_powerdown);
   wire pd_wake = req_valid || (pending != 3'b000) || sr_go;

   // ************************************************************
   // Power state machine and command choice
   // ************************************************************
   always_comb
   begin
      next_state = pstate;
      next_cmd = CMD_NONE;
      unique case (pstate)
         PS_RUN:
         begin
            if (can_ref)
               next_cmd = rows_open ? CMD_PRE_ALL : CMD_REFRESH;
            else if (req_valid)
            begin
               // The requester still holds a finished request during its done cycle.
               if (!ref_block && user_ok && !req_done)
                  next_cmd = is_wr ? CMD_WRITE : CMD_READ;
            end
            else if (sr_go || pd_go)
            begin
               if (need_pre)
                  next_cmd = CMD_PRE_ALL;
               else if (sr_go)
               begin
                  next_cmd = CMD_SR_ENTER;
                  next_state = PS_SR;
               end
               else
               begin
                  next_cmd = CMD_PD_ENTER;
                  next_state = PS_PD;
               end
            end
         end
         PS_PD:
         begin
            if (pd_wake && st_cnt >= powerdown_min_stay)
            begin
               next_cmd = CMD_PD_EXIT;
               next_state = PS_PD_EXIT;
            end
         end
         PS_PD_EXIT:
         begin
            if (st_cnt >= powerdown_exit_gap)
               next_state = PS_RUN;
         end
         PS_SR:
         begin
            if (req_valid && st_cnt >= selfrefresh_min_stay)
            begin
               next_cmd = CMD_SR_EXIT;
               next_state = PS_SR_EXIT;
            end
         end
         PS_SR_EXIT:
         begin
            if (st_cnt >= selfrefresh_exit_gap)
               next_state = PS_RUN;
         end
         default:
         begin
            next_state = PS_RUN;
         end
      endcase
   end

   wire issue_rd = (next_cmd == CMD_READ);
   wire issue_wr = (next_cmd == CMD_WRITE);
   wire state_move = (next_state != pstate);
   wire [8:0] next_st_cnt = state_move ? 9'h001 : ((st_cnt == 9'h1FF) ? st_cnt : st_cnt + 9'h001);
   wire next_rows_open = (issue_rd | issue_wr) | (rows_open & (next_cmd != CMD_PRE_ALL));
   wire next_rmw_wr = (issue_rd & req_rmw & ~rmw_wr) | (rmw_wr & ~issue_wr);
   wire next_cke = (next_state != PS_PD) && (next_state != PS_SR);

   // Counters restart at one so that a gap of N lets the next command go N clocks later.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         since_rd <= '1;
         since_wr <= '1;
         since_ref <= 8'hFF;
      end
      else
      begin
         since_rd <= issue_rd ? GAP_W'(1) : bump(since_rd);
         since_wr <= issue_wr ? GAP_W'(1) : bump(since_wr);
         since_ref <= pend_dec ? 8'h01 : ((since_ref == 8'hFF) ? since_ref : since_ref + 8'h01);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         last_rd_cs <= 3'b000;
         last_wr_cs <= 3'b000;
      end
      else
      begin
         if (issue_rd)
            last_rd_cs <= req_cs;
         if (issue_wr)
            last_wr_cs <= req_cs;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ref_cnt <= 16'h0000;
         pending <= 3'b000;
         ref_block <= 1'b0;
         idle_cnt <= '0;
      end
      else
      begin
         ref_cnt <= next_ref_cnt;
         pending <= next_pending;
         ref_block <= next_ref_block;
         idle_cnt <= next_idle;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pstate <= PS_RUN;
         st_cnt <= 9'h000;
         rows_open <= 1'b0;
         rmw_wr <= 1'b0;
      end
      else
      begin
         pstate <= next_state;
         st_cnt <= next_st_cnt;
         rows_open <= next_rows_open;
         rmw_wr <= next_rmw_wr;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd_valid <= 1'b0;
         cmd_code <= CMD_NONE;
         cmd_cs <= 3'b000;
         cmd_bank <= 3'b000;
         req_done <= 1'b0;
         mem_cke <= 1'b1;
      end
      else
      begin
         cmd_valid <= (next_cmd != CMD_NONE);
         cmd_code <= next_cmd;
         cmd_cs <= (issue_rd | issue_wr) ? req_cs : 3'b000;
         cmd_bank <= (issue_rd | issue_wr) ? req_bank : 3'b000;
         req_done <= (issue_rd & ~req_rmw) | issue_wr;
         mem_cke <= next_cke;
      end
   end

   // ************************************************************
   // APB read path
   // ************************************************************
   wire [31:0] status_word = {21'h00_0000, 3'(pstate), 3'b000, rows_open, ref_block, pending};
   wire [31:0] rd_value = (sel_idx == IDX_STATUS) ? status_word :
      (sel_idx < 3'(NCFG)) ? cfg[sel_idx] : 32'h0000_0000;

   // The slave answers in the first access cycle, so pready is a registered setup flag.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apb_setup;
         prdata <= (apb_setup & ~pwrite) ? rd_value : 32'h0000_0000;
         pslverr <= apb_setup & (sel_idx == 3'(UNMAPPED));
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_pending_limit:
   assert property ($stable(refresh_config) |-> pending <= max_pending_refresh)
      else $error("pending refreshes above limit");
   a_ref_spacing:
   assert property (cmd_valid && cmd_code == CMD_REFRESH
      |-> $past(since_ref) >= $past(refresh_min_spacing))
      else $error("refresh spacing violated");
   a_idle_refresh:
   assert property (pstate == PS_RUN && pending != 3'b000 && !req_valid && ref_spaced
      |=> cmd_valid && (cmd_code == CMD_REFRESH || cmd_code == CMD_PRE_ALL))
      else $error("idle pending refresh not issued");
   a_block_hold:
   assert property (cmd_valid && (cmd_code == CMD_READ || cmd_code == CMD_WRITE)
      |-> !$past(ref_block))
      else $error("access issued while refresh block set");
   a_pd_precharge:
   assert property (cmd_valid && cmd_code == CMD_PD_ENTER && $past(precharge_only_powerdown)
      |-> !$past(rows_open))
      else $error("power-down entered with open rows");
   a_sr_idle:
   assert property (cmd_valid && cmd_code == CMD_SR_ENTER
      |-> $past(idle_cnt) >= ($past(IDLE_W'(selfrefresh_idle_delay)) << 10))
      else $error("self-refresh entered too early");
   a_pd_idle:
   assert property (cmd_valid && cmd_code == CMD_PD_ENTER
      |-> $past(idle_cnt) >= ($past(IDLE_W'(powerdown_idle_delay)) << 2))
      else $error("power-down entered too early");
   a_sr_enable:
   assert property (cmd_valid && cmd_code == CMD_SR_ENTER |-> $past(auto_selfrefresh_enable))
      else $error("self-refresh entered while disabled");
   a_pd_enable:
   assert property (cmd_valid && cmd_code == CMD_PD_ENTER |-> $past(auto_powerdown_enable))
      else $error("power-down entered while disabled");
   a_w2r_gap:
   assert property (cmd_valid && cmd_code == CMD_READ |-> $past(ok_w2r))
      else $error("write to read gap violated");
   a_pd_stay:
   assert property (cmd_valid && cmd_code == CMD_PD_EXIT
      |-> $past(st_cnt) >= $past(powerdown_min_stay) && !$past(mem_cke) && mem_cke)
      else $error("power-down left too soon");
   a_sr_stay:
   assert property (cmd_valid && cmd_code == CMD_SR_EXIT
      |-> $past(st_cnt) >= $past(selfrefresh_min_stay))
      else $error("self-refresh left too soon");
endmodule

// *** hdl/drfpt_map.svh ***
// Register offsets, field ranges, write masks and reset values of the refresh and power block.
// Assumes a 32-bit APB with byte addresses, one aligned word per register.
`ifndef DRFPT_MAP_SVH
`define DRFPT_MAP_SVH
`define DRFPT_OFS_CSBANK 8'h00
`define DRFPT_OFS_REFRESH 8'h04
`define DRFPT_OFS_POWER 8'h08
`define DRFPT_OFS_SPACE0 8'h0C
`define DRFPT_OFS_SPACE1 8'h10
`define DRFPT_OFS_SHIFT 8'h14
`define DRFPT_OFS_STATUS 8'h18
`define DRFPT_RST_WORD 32'h0000_0000
`define DRFPT_MSK_CSBANK 32'h0000_01C7
`define DRFPT_MSK_REFRESH 32'h07FF_FFFF
`define DRFPT_MSK_POWER 32'h007F_FFFC
`define DRFPT_MSK_SPACE0 32'hFFFF_FFFF
`define DRFPT_MSK_SPACE1 32'h7FFF_FFFF
`define DRFPT_MSK_SHIFT 32'h001F_1F00
`define DRFPT_F_CSMSK 8:6
`define DRFPT_F_BNKMSK 2:0
`define DRFPT_F_MAXREF 26:24
`define DRFPT_F_REFSP 23:16
`define DRFPT_F_REFINT 15:0
`define DRFPT_B_PCHONLY 22
`define DRFPT_F_SRDLY 21:12
`define DRFPT_F_PDDLY 11:4
`define DRFPT_B_ASREN 3
`define DRFPT_B_APDEN 2
`define DRFPT_F_RMW 31:28
`define DRFPT_F_R2W 27:24
`define DRFPT_F_W2WCS 23:20
`define DRFPT_F_W2W 19:16
`define DRFPT_F_R2RCS 15:12
`define DRFPT_F_R2R 11:8
`define DRFPT_F_W2RCS 7:4
`define DRFPT_F_W2R 3:0
`define DRFPT_B_SREXHI 30
`define DRFPT_B_W2RCSHI 28
`define DRFPT_B_W2RHI 27
`define DRFPT_F_PDEXIT 25:20
`define DRFPT_F_PDMIN 19:16
`define DRFPT_F_SREXIT 15:8
`define DRFPT_F_SRMIN 7:0
`define DRFPT_F_CSSH 20:16
`define DRFPT_F_BNKSH 12:8
`define DRFPT_F_STPEND 2:0
`define DRFPT_B_STBLOCK 3
`define DRFPT_B_STOPEN 4
`define DRFPT_F_STSTATE 10:8
`define DRFPT_PD_UNIT_LOG2 2
`define DRFPT_SR_UNIT_LOG2 10
`endif

// *** hdl/drfpt_pkg.sv ***
// Types shared by the refresh and power block and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package drfpt_pkg;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_READ, CMD_WRITE, CMD_REFRESH, CMD_PRE_ALL,
      CMD_PD_ENTER, CMD_PD_EXIT, CMD_SR_ENTER, CMD_SR_EXIT
   } drfpt_cmd_t;
   typedef enum logic [2:0] {
      PS_RUN, PS_PD, PS_PD_EXIT, PS_SR, PS_SR_EXIT
   } drfpt_pstate_t;
endpackage

// *** testbench/drfpt_mem_model.sv ***
// Stand-in for the DDR2 devices on the command side of the scheduler core.
// Assumes commands arrive as one-cycle pulses with the clock enable alongside.
`timescale 1ns/10ps
module drfpt_mem_model
(
   input wire logic clk,
   input wire logic cmd_valid,
   input wire drfpt_pkg::drfpt_cmd_t cmd_code,
   input wire logic mem_cke,
   output int n_refresh,
   output int n_sleep_access
);
   import drfpt_pkg::*;
   // A real device ignores reads and writes while its clock enable is low.
   always @(posedge clk)
   begin
      if (cmd_valid === 1'b1 && cmd_code == CMD_REFRESH)
         n_refresh++;
      if (cmd_valid === 1'b1 && mem_cke !== 1'b1 && cmd_code inside {CMD_READ, CMD_WRITE})
         n_sleep_access++;
   end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench of the scheduler core: registers, spacing, refresh, power saving.
// Assumes the core, its package and the register map header.
`timescale 1ns/10ps
`include "drfpt_map.svh"
module tb_top;
   import drfpt_pkg::*;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, er, rows = 1'b0;
   logic req_valid, req_write, req_rmw, req_done, cmd_valid, mem_cke, lastw, cke_q = 1'b1;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, req_addr, rd, sp0, lf = 32'h0001_4489;
   logic [2:0] cmd_cs, cmd_bank, exp_cs, exp_bk, lastcs;
   drfpt_cmd_t cmd_code;
   int failures, n_compared, cyc, idle, lastc = -99, lastref = -99, sp_ref, pd_need, t0, n0;
   int n_ref, n_bad;
   logic [31:0] msk [5] = '{`DRFPT_MSK_CSBANK, `DRFPT_MSK_REFRESH, `DRFPT_MSK_POWER,
      `DRFPT_MSK_SPACE0, `DRFPT_MSK_SPACE1};
   drfpt_core u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write), .req_rmw(req_rmw),
      .req_addr(req_addr), .req_done(req_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_cs(cmd_cs), .cmd_bank(cmd_bank), .mem_cke(mem_cke));
   drfpt_mem_model u_mem (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .mem_cke(mem_cke), .n_refresh(n_ref), .n_sleep_access(n_bad));
   // ****************************************************************
   // Tasks and reference model
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int gap(input logic pw, input logic w, input logic same);
      int n;
      if (!pw)
         n = w ? sp0[27:24] : (same ? sp0[11:8] : sp0[15:12]);
      else
         n = w ? (same ? sp0[19:16] : sp0[23:20]) : (same ? sp0[3:0] : sp0[7:4]);
      // A read-modify-write also keeps its own turnaround between its read and write.
      if (!pw && w && req_rmw === 1'b1 && sp0[31:28] > n)
         n = sp0[31:28];
      return (n < 1) ? 1 : n;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic req(input logic w, input logic [31:0] a);
      @(posedge clk);
      exp_cs = 3'(a >> 4) & 3'b011;
      exp_bk = a[2:0] & 3'b101;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      do
         @(posedge clk);
      while (req_done !== 1'b1);
      req_valid <= 1'b0;
   endtask
   // Outputs are read at the edge, before the core's own updates land.
   always @(posedge clk)
   begin
      cyc++;
      idle = (req_valid === 1'b1 || cmd_code == CMD_REFRESH) ? 0 : idle + 1;
      if (cke_q === 1'b1 && mem_cke === 1'b0)
      begin
         chk(32'(idle >= pd_need), 1, "idle before sleep");
         chk({31'h0, rows}, 32'h0, "rows closed");
      end
      cke_q = mem_cke;
      if (cmd_valid === 1'b1)
         rows = (cmd_code inside {CMD_READ, CMD_WRITE}) || (rows && cmd_code != CMD_PRE_ALL);
      if (cmd_valid === 1'b1 && cmd_code == CMD_REFRESH)
      begin
         chk(32'(cyc - lastref >= sp_ref), 1, "refresh spacing");
         lastref = cyc;
      end
      if (cmd_valid === 1'b1 && cmd_code inside {CMD_READ, CMD_WRITE})
      begin
         chk(32'(cyc - lastc >= gap(lastw, cmd_code == CMD_WRITE, lastcs == cmd_cs)), 1,
            "spacing");
         chk({26'h0, cmd_cs, cmd_bank}, {26'h0, exp_cs, exp_bk}, "cs bank");
         lastc = cyc;
         lastw = (cmd_code == CMD_WRITE);
         lastcs = cmd_cs;
      end
   end
   initial
   begin
      {arst_n, psel, penable, pwrite, req_valid, req_write, req_rmw} = 7'h00;
      {paddr, pwdata, req_addr} = 72'h0;
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #(25 * 20000);
      failures++;
      test_done();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0, "reset value");
         apb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, msk[i], "readback");
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk({rd[30:0], er}, 32'h0000_0001, "unmapped");
      apb(1'b1, `DRFPT_OFS_REFRESH, 32'h0);
      apb(1'b1, `DRFPT_OFS_POWER, 32'h0);
      apb(1'b1, `DRFPT_OFS_SPACE1, 32'h0);
      apb(1'b1, `DRFPT_OFS_CSBANK, 32'h0000_00C5);
      apb(1'b1, `DRFPT_OFS_SHIFT, 32'h0004_0000);
      lf = lfsr(lf);
      sp0 = lf | 32'h3333_3333;
      apb(1'b1, `DRFPT_OFS_SPACE0, sp0);
      apb(1'b1, `DRFPT_OFS_REFRESH, 32'h0100_0014);
      for (int i = 0; i < 16; i++)
      begin
         lf = lfsr(lf);
         req_rmw <= lf[8];
         req(lf[7], {25'h0, lf[6:0]});
      end
      req_rmw <= 1'b0;
      sp_ref = 3;
      t0 = cyc;
      n0 = n_ref;
      apb(1'b1, `DRFPT_OFS_REFRESH, 32'h0203_0014);
      repeat (8)
      begin
         repeat (50) @(posedge clk);
         apb(1'b0, `DRFPT_OFS_STATUS, 32'h0);
         chk(32'(rd[2:0] <= 3'd2), 1, "pending");
      end
      t0 = (cyc - t0) / 20;
      chk(32'(n_ref - n0 >= t0 - 3 && n_ref - n0 <= t0 + 1), 1, "refresh rate");
      apb(1'b1, `DRFPT_OFS_REFRESH, 32'h0);
      pd_need = 8;
      req(1'b1, 32'h0000_0026);
      apb(1'b1, `DRFPT_OFS_POWER, 32'h0040_0024);
      repeat (60) @(posedge clk);
      chk({31'h0, mem_cke}, 32'h0, "power-down");
      req(1'b0, 32'h0000_0005);
      pd_need = 1024;
      apb(1'b1, `DRFPT_OFS_POWER, 32'h0000_1008);
      repeat (1200) @(posedge clk);
      chk({31'h0, mem_cke}, 32'h0, "self-refresh");
      req(1'b1, 32'h0000_0013);
      apb(1'b1, `DRFPT_OFS_POWER, 32'h0);
      repeat (1200) @(posedge clk);
      chk({31'h0, mem_cke}, 32'h1, "no sleep");
      chk(32'(n_bad), 32'h0, "asleep access");
      test_done();
   end
endmodule
